// *** tw_if.sv ***
`timescale 1ns/1ps
interface tw_if;

    // ---------------------------------------------------------------
    // Bus wires
    // ---------------------------------------------------------------
    logic scl;
    logic sda_ctl_o;
    logic sda_ctl_oe;
    logic sda_tgt_o;
    logic sda_tgt_oe;
    logic sda;

    // Open drain with pull-up: any enabled low wins
    assign sda = ~((sda_ctl_oe & ~sda_ctl_o) | (sda_tgt_oe & ~sda_tgt_o));

    modport target (
        input  scl,
        input  sda,
        output sda_tgt_o,
        output sda_tgt_oe
    );

    modport controller (
        output scl,
        output sda_ctl_o,
        output sda_ctl_oe,
        input  sda
    );

endinterface

// *** tw_pkg.sv ***
package tw_pkg;

    // ---------------------------------------------------------------
    // State and data types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        TGT_IDLE,
        TGT_ADDR,
        TGT_ACK,
        TGT_DATA,
        TGT_IGNORE
    } tgt_state_e;

    typedef enum logic [2:0] {
        CTL_IDLE,
        CTL_START,
        CTL_BIT,
        CTL_STOP,
        CTL_BUF
    } ctl_state_e;

    typedef logic [7:0] byte_t;

endpackage

// *** tw_props.sv ***
`timescale 1ns/1ps
module tw_props (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic scl,
    input wire logic sda_ctl_o,
    input wire logic sda_ctl_oe,
    input wire logic sda_tgt_o,
    input wire logic sda_tgt_oe,
    input wire logic sda
);
    // ---------------------------------------------------------------
    // Helper counters
    // ---------------------------------------------------------------
    // Saturating, so a stuck line cannot wrap and hide
    logic [7:0] lo_cnt_q;
    logic [7:0] lo_cnt_d;
    logic [7:0] oe_cnt_q;
    logic [7:0] oe_cnt_d;

    always_comb begin
        lo_cnt_d = scl ? 8'h00 : ((lo_cnt_q == 8'hFF) ? lo_cnt_q : lo_cnt_q + 8'h01);
        oe_cnt_d = !sda_tgt_oe ? 8'h00 : ((oe_cnt_q == 8'hFF) ? oe_cnt_q : oe_cnt_q + 8'h01);
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            lo_cnt_q <= 8'h00;
            oe_cnt_q <= 8'h00;
        end else begin
            lo_cnt_q <= lo_cnt_d;
            oe_cnt_q <= oe_cnt_d;
        end
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);

    a_tgt_pull_only: assert property (sda_tgt_oe |-> !sda_tgt_o)
        else $error("target drives data high");
    a_ctl_pull_only: assert property (sda_ctl_oe |-> !sda_ctl_o)
        else $error("controller drives data high");
    a_ack_rise_low: assert property ($rose(sda_tgt_oe) |-> !scl [*8])
        else $error("ack pulled outside clock low phase");
    a_ack_fall_low: assert property ($fell(sda_tgt_oe) |-> !scl)
        else $error("ack released while clock high");
    a_ack_spans_pulse: assert property ($rose(sda_tgt_oe) |-> ##[15:30] (scl && sda_tgt_oe))
        else $error("ack not held into clock pulse");
    a_ack_one_clock: assert property (oe_cnt_q <= 8'h3C)
        else $error("target holds data longer than one clock");
    a_start_hold: assert property ($fell(sda) && scl |-> scl [*8])
        else $error("start hold too short");
    a_stop_then_free: assert property ($rose(sda) && scl |-> (sda && scl) [*8])
        else $error("bus not free after stop");
    a_scl_low_time: assert property ($rose(scl) |-> lo_cnt_q >= 8'h1A)
        else $error("clock low phase too short");
    a_scl_high_time: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
endmodule

// *** tw_regs.svh ***
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

// ---------------------------------------------------------------
// Clock and bus timing
// ---------------------------------------------------------------
`define TW_CLK_HZ        20000000
`define TW_CLK_MHZ       20
`define TW_SCL_MAX_HZ    400000
`define TW_T_LOW_NS      1300
`define TW_T_HIGH_NS     700
`define TW_T_HD_STA_NS   600
`define TW_T_SU_STO_NS   600
`define TW_T_BUF_NS      1300
// Least times round up to whole cycles
`define TW_CYC_UP(ns)    ((((ns) * `TW_CLK_MHZ) + 999) / 1000)

// ---------------------------------------------------------------
// Address byte and frame layout
// ---------------------------------------------------------------
`define TW_FIXED_PREFIX  5'h19
`define TW_DIR_WRITE     1'h0
`define TW_ACK_BIT       4'h8
`define TW_LAST_BYTE     2'h2

`endif

// *** wr_controller.sv ***
`timescale 1ns/1ps
`include "tw_regs.svh"

module wr_controller
    import tw_pkg::*;
#(
    parameter int SCL_HZ = `TW_SCL_MAX_HZ
) (
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RSTN,
    input  wire logic       I_REQ,
    input  wire logic [6:0] I_TGT_ADDR,
    input  wire logic [7:0] I_REG_ADDR,
    input  wire logic [7:0] I_WR_DATA,
    output logic            O_READY,
    output logic            O_DONE,
    output logic            O_NACK,
    tw_if.controller        BUS
);

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int PER_I  = `TW_CLK_HZ / SCL_HZ;
    localparam int LOW_I  = `TW_CYC_UP(`TW_T_LOW_NS);
    localparam int HIGH_I = `TW_CYC_UP(`TW_T_HIGH_NS);
    localparam logic [7:0] PER_M1 = 8'(PER_I - 1);
    localparam logic [7:0] LOW_C  = 8'(LOW_I);
    localparam logic [7:0] MID_C  = 8'(LOW_I / 2);
    localparam logic [7:0] HD_STA = 8'(`TW_CYC_UP(`TW_T_HD_STA_NS));
    localparam logic [7:0] STO_C  = 8'(LOW_I + `TW_CYC_UP(`TW_T_SU_STO_NS));
    localparam logic [7:0] BUF_C  = 8'(`TW_CYC_UP(`TW_T_BUF_NS));

    // Period is fixed by SCL_HZ; a rate too short for the low, high or stop times is an error
    if (SCL_HZ > `TW_SCL_MAX_HZ || PER_I > 256 || PER_I - LOW_I < HIGH_I ||
        LOW_I + `TW_CYC_UP(`TW_T_SU_STO_NS) >= PER_I) begin : g_bad_rate
        $error("wr_controller cannot meet the bus timing at this rate");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    ctl_state_e state_q;
    ctl_state_e state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [1:0] byte_q;
    logic [1:0] byte_d;
    byte_t      shift_q;
    byte_t      shift_d;
    byte_t      reg_q;
    byte_t      reg_d;
    byte_t      dat_q;
    byte_t      dat_d;
    logic       scl_q;
    logic       scl_d;
    logic       pull_q;
    logic       pull_d;
    logic       nack_q;
    logic       nack_d;
    logic       done_q;
    logic       done_d;
    logic       sda_s1_q;
    logic       sda_s2_q;

    assign O_READY = (state_q == CTL_IDLE);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 8'h01;
        bit_d   = bit_q;
        byte_d  = byte_q;
        shift_d = shift_q;
        reg_d   = reg_q;
        dat_d   = dat_q;
        scl_d   = scl_q;
        pull_d  = pull_q;
        nack_d  = nack_q;
        done_d  = 1'b0;
        case (state_q)
            CTL_IDLE: begin
                // Both lines released while no transfer runs
                scl_d  = 1'b1;
                pull_d = 1'b0;
                cnt_d  = 8'h00;
                if (I_REQ) begin
                    state_d = CTL_START;
                    shift_d = {I_TGT_ADDR, `TW_DIR_WRITE};
                    reg_d   = I_REG_ADDR;
                    dat_d   = I_WR_DATA;
                    bit_d   = 4'h0;
                    byte_d  = 2'h0;
                    nack_d  = 1'b0;
                    pull_d  = 1'b1;
                end
            end
            CTL_START: begin
                if (cnt_q == HD_STA) begin
                    state_d = CTL_BIT;
                    cnt_d   = 8'h00;
                end
            end
            CTL_BIT: begin
                if (cnt_q == 8'h00) begin
                    scl_d = 1'b0;
                end
                // Data changes mid-low, clear of hold and setup
                if (cnt_q == MID_C) begin
                    pull_d = (bit_q == `TW_ACK_BIT) ? 1'b0 : ~shift_q[7];
                end
                if (cnt_q == LOW_C) begin
                    scl_d = 1'b1;
                end
                if (cnt_q == PER_M1) begin
                    cnt_d = 8'h00;
                    if (bit_q == `TW_ACK_BIT) begin
                        bit_d = 4'h0;
                        if (sda_s2_q) begin
                            nack_d  = 1'b1;
                            state_d = CTL_STOP;
                        end else if (byte_q == `TW_LAST_BYTE) begin
                            state_d = CTL_STOP;
                        end else begin
                            byte_d  = byte_q + 2'h1;
                            shift_d = (byte_q == 2'h0) ? reg_q : dat_q;
                        end
                    end else begin
                        bit_d   = bit_q + 4'h1;
                        shift_d = {shift_q[6:0], 1'b0};
                    end
                end
            end
            CTL_STOP: begin
                if (cnt_q == 8'h00) begin
                    scl_d = 1'b0;
                end
                if (cnt_q == MID_C) begin
                    pull_d = 1'b1;
                end
                if (cnt_q == LOW_C) begin
                    scl_d = 1'b1;
                end
                if (cnt_q == STO_C) begin
                    pull_d  = 1'b0;
                    state_d = CTL_BUF;
                    cnt_d   = 8'h00;
                end
            end
            CTL_BUF: begin
                if (cnt_q == BUF_C) begin
                    state_d = CTL_IDLE;
                    done_d  = 1'b1;
                end
            end
            default: begin
                state_d = CTL_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_q  <= CTL_IDLE;
            cnt_q    <= 8'h00;
            bit_q    <= 4'h0;
            byte_q   <= 2'h0;
            shift_q  <= 8'h00;
            reg_q    <= 8'h00;
            dat_q    <= 8'h00;
            scl_q    <= 1'b1;
            pull_q   <= 1'b0;
            nack_q   <= 1'b0;
            done_q   <= 1'b0;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            bit_q    <= bit_d;
            byte_q   <= byte_d;
            shift_q  <= shift_d;
            reg_q    <= reg_d;
            dat_q    <= dat_d;
            scl_q    <= scl_d;
            pull_q   <= pull_d;
            nack_q   <= nack_d;
            done_q   <= done_d;
            sda_s1_q <= BUS.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    assign BUS.scl        = scl_q;
    assign BUS.sda_ctl_o  = 1'b0;
    assign BUS.sda_ctl_oe = pull_q;
    assign O_DONE         = done_q;
    assign O_NACK         = nack_q;

endmodule

// *** wr_target.sv ***
`timescale 1ns/1ps
`include "tw_regs.svh"

// Operation
// - Seven-bit address in bits 7..1, direction bit 0
// - Writes only; direction bit set means not us
// - Top five address bits fixed at 11001
// - Bits 2..1 come from the strap pin
// - Strap ground 00, supply 11, clock 01, data 10
// - Sample data while serial clock is high
// - Controller leaves data high when bus idle
// - Start is data falling while clock high
// - After start, shift address byte and compare
// - Clock input only; data pulled low or released
// - Controller clock never above 400 kHz
// - Hold data low on ack pulse after match
// - Controller stops when acknowledge is missing
// - Register byte then data byte, each acknowledged
// - Stop is data rising while clock high; idle
module wr_target
    import tw_pkg::*;
#(
    parameter int ADDR_W = 7
) (
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RSTN,
    input  wire logic       I_ADDR_SEL,
    tw_if.target            BUS,
    output logic            O_ADDRESSED,
    output logic            O_WR_STB,
    output logic [7:0]      O_REG_ADDR,
    output logic [7:0]      O_WR_DATA
);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (ADDR_W != 7) begin : g_bad_width
        $error("wr_target serves only a seven-bit address");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic       scl_s1_q;
    logic       scl_s2_q;
    logic       scl_s3_q;
    logic       sda_s1_q;
    logic       sda_s2_q;
    logic       sda_s3_q;
    logic       sel_s1_q;
    logic       sel_s2_q;
    logic       scl_s3_d;
    logic       sda_s3_d;

    tgt_state_e state_q;
    tgt_state_e state_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    byte_t      shift_q;
    byte_t      shift_d;
    logic [1:0] byte_idx_q;
    logic [1:0] byte_idx_d;
    logic       sel_idle_q;
    logic       sel_idle_d;
    logic       sel_start_q;
    logic       sel_start_d;
    logic       sel_low_q;
    logic       sel_low_d;
    logic       first_fall_q;
    logic       first_fall_d;
    logic       ack_oe_q;
    logic       ack_oe_d;
    logic       addressed_q;
    logic       addressed_d;
    logic       stb_q;
    logic       stb_d;
    byte_t      reg_addr_q;
    byte_t      reg_addr_d;
    byte_t      wr_data_q;
    byte_t      wr_data_d;

    logic       rise;
    logic       fall;
    logic       start_seen;
    logic       stop_seen;
    logic [1:0] strapped_address_bits;
    logic [6:0] own_address;
    logic       direction_bit;

    // ---------------------------------------------------------------
    // Bus conditions
    // ---------------------------------------------------------------
    // Only the second and third stages are looked at
    assign rise       = scl_s2_q & ~scl_s3_q;
    assign fall       = ~scl_s2_q & scl_s3_q;
    assign start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_seen  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    // Strap seen in three bus states: idle high/high, start, first low
    // Ground 000, supply 111, clock 110, data 100
    assign strapped_address_bits = {sel_idle_q & (sel_low_q | ~sel_start_q),
                                    sel_start_q};
    assign own_address   = {`TW_FIXED_PREFIX, strapped_address_bits};
    assign direction_bit = shift_q[0];

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        scl_s3_d     = scl_s2_q;
        sda_s3_d     = sda_s2_q;
        state_d      = state_q;
        bit_cnt_d    = bit_cnt_q;
        shift_d      = shift_q;
        byte_idx_d   = byte_idx_q;
        sel_idle_d   = sel_idle_q;
        sel_start_d  = sel_start_q;
        sel_low_d    = sel_low_q;
        first_fall_d = first_fall_q;
        ack_oe_d     = ack_oe_q;
        addressed_d  = addressed_q;
        stb_d        = 1'b0;
        reg_addr_d   = reg_addr_q;
        wr_data_d    = wr_data_q;

        // Idle strap look only while both lines rest high
        if (state_q == TGT_IDLE && scl_s2_q && sda_s2_q) begin
            sel_idle_d = sel_s2_q;
        end

        if (start_seen) begin
            state_d      = TGT_ADDR;
            bit_cnt_d    = 4'h0;
            byte_idx_d   = 2'h0;
            sel_start_d  = sel_s2_q;
            first_fall_d = 1'b1;
            ack_oe_d     = 1'b0;
            addressed_d  = 1'b0;
        end else if (stop_seen) begin
            state_d     = TGT_IDLE;
            ack_oe_d    = 1'b0;
            addressed_d = 1'b0;
        end else begin
            case (state_q)
                TGT_IDLE: begin
                    ack_oe_d = 1'b0;
                end
                TGT_ADDR, TGT_DATA: begin
                    if (fall && first_fall_q) begin
                        first_fall_d = 1'b0;
                        sel_low_d    = sel_s2_q;
                    end
                    if (rise) begin
                        shift_d   = {shift_q[6:0], sda_s2_q};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (fall && bit_cnt_q == `TW_ACK_BIT) begin
                        bit_cnt_d = 4'h0;
                        if (state_q == TGT_ADDR) begin
                            if (shift_q[7:1] == own_address &&
                                direction_bit == `TW_DIR_WRITE) begin
                                state_d     = TGT_ACK;
                                ack_oe_d    = 1'b1;
                                addressed_d = 1'b1;
                            end else begin
                                state_d = TGT_IGNORE;
                            end
                        end else begin
                            state_d  = TGT_ACK;
                            ack_oe_d = 1'b1;
                            case (byte_idx_q)
                                2'h0: begin
                                    reg_addr_d = shift_q;
                                    byte_idx_d = 2'h1;
                                end
                                2'h1: begin
                                    wr_data_d  = shift_q;
                                    stb_d      = 1'b1;
                                    byte_idx_d = `TW_LAST_BYTE;
                                end
                                default: begin
                                    // Extra bytes land at the next register
                                    reg_addr_d = reg_addr_q + 8'h01;
                                    wr_data_d  = shift_q;
                                    stb_d      = 1'b1;
                                end
                            endcase
                        end
                    end
                end
                TGT_ACK: begin
                    // Released on the falling edge ending the ack pulse
                    if (fall) begin
                        ack_oe_d = 1'b0;
                        state_d  = TGT_DATA;
                    end
                end
                TGT_IGNORE: begin
                    ack_oe_d = 1'b0;
                end
                default: begin
                    state_d  = TGT_IDLE;
                    ack_oe_d = 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            scl_s1_q     <= 1'b1;
            scl_s2_q     <= 1'b1;
            scl_s3_q     <= 1'b1;
            sda_s1_q     <= 1'b1;
            sda_s2_q     <= 1'b1;
            sda_s3_q     <= 1'b1;
            sel_s1_q     <= 1'b0;
            sel_s2_q     <= 1'b0;
            state_q      <= TGT_IDLE;
            bit_cnt_q    <= 4'h0;
            shift_q      <= 8'h00;
            byte_idx_q   <= 2'h0;
            sel_idle_q   <= 1'b0;
            sel_start_q  <= 1'b0;
            sel_low_q    <= 1'b0;
            first_fall_q <= 1'b0;
            ack_oe_q     <= 1'b0;
            addressed_q  <= 1'b0;
            stb_q        <= 1'b0;
            reg_addr_q   <= 8'h00;
            wr_data_q    <= 8'h00;
        end else begin
            scl_s1_q     <= BUS.scl;
            scl_s2_q     <= scl_s1_q;
            scl_s3_q     <= scl_s3_d;
            sda_s1_q     <= BUS.sda;
            sda_s2_q     <= sda_s1_q;
            sda_s3_q     <= sda_s3_d;
            sel_s1_q     <= I_ADDR_SEL;
            sel_s2_q     <= sel_s1_q;
            state_q      <= state_d;
            bit_cnt_q    <= bit_cnt_d;
            shift_q      <= shift_d;
            byte_idx_q   <= byte_idx_d;
            sel_idle_q   <= sel_idle_d;
            sel_start_q  <= sel_start_d;
            sel_low_q    <= sel_low_d;
            first_fall_q <= first_fall_d;
            ack_oe_q     <= ack_oe_d;
            addressed_q  <= addressed_d;
            stb_q        <= stb_d;
            reg_addr_q   <= reg_addr_d;
            wr_data_q    <= wr_data_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Never drives high: output level held low, enable does the work
    assign BUS.sda_tgt_o  = 1'b0;
    assign BUS.sda_tgt_oe = ack_oe_q;
    assign O_ADDRESSED    = addressed_q;
    assign O_WR_STB       = stb_q;
    assign O_REG_ADDR     = reg_addr_q;
    assign O_WR_DATA      = wr_data_q;

endmodule

// *** write_only_serial_slave_front_end_tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module write_only_serial_slave_front_end_tb;
    import tw_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic       clk_sys;
    logic       rst_n;
    logic [1:0] strap_m;
    logic       addr_sel;
    logic       req;
    logic [6:0] tgt_addr;
    byte_t      reg_addr;
    byte_t      wr_data;
    logic       ready;
    logic       done;
    logic       nack;
    logic       addressed;
    logic       wr_stb;
    byte_t      reg_o;
    byte_t      data_o;
    byte_t      got_reg;
    byte_t      got_data;
    logic [6:0] exp_a;
    int         stb_n;
    int         stb0;
    bit         seen_addr;
    int         bad_count;
    int         checks_done;

    tw_if bus ();

    // Strap follows a live bus line in two of the four modes
    assign addr_sel = (strap_m == 2'h0) ? 1'b0 : (strap_m == 2'h1) ? 1'b1 :
                      (strap_m == 2'h2) ? bus.scl : bus.sda;

    wr_target u_wr_target (.I_CLK_SYS(clk_sys), .I_RSTN(rst_n), .I_ADDR_SEL(addr_sel),
        .BUS(bus), .O_ADDRESSED(addressed), .O_WR_STB(wr_stb), .O_REG_ADDR(reg_o),
        .O_WR_DATA(data_o));
    wr_controller u_wr_controller (.I_CLK_SYS(clk_sys), .I_RSTN(rst_n), .I_REQ(req),
        .I_TGT_ADDR(tgt_addr), .I_REG_ADDR(reg_addr), .I_WR_DATA(wr_data),
        .O_READY(ready), .O_DONE(done), .O_NACK(nack), .BUS(bus));
    tw_props u_tw_props (.I_CLK_SYS(clk_sys), .I_RSTN(rst_n), .scl(bus.scl),
        .sda_ctl_o(bus.sda_ctl_o), .sda_ctl_oe(bus.sda_ctl_oe), .sda_tgt_o(bus.sda_tgt_o),
        .sda_tgt_oe(bus.sda_tgt_oe), .sda(bus.sda));

    // ---------------------------------------------------------------
    // Clock, monitor, tasks
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        if (wr_stb === 1'b1) begin
            stb_n++;
            got_reg = reg_o;
            got_data = data_o;
        end
        if (addressed === 1'b1) seen_addr = 1'b1;
    end

    function automatic logic [1:0] strap_bits(input logic [1:0] m);
        case (m)
            2'h0: strap_bits = 2'h0;
            2'h1: strap_bits = 2'h3;
            2'h2: strap_bits = 2'h1;
            default: strap_bits = 2'h2;
        endcase
    endfunction

    task automatic final_report();
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Reset and strap change land on a rising edge like every other input
    task automatic do_reset(input logic [1:0] m);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        req <= 1'b0;
        strap_m <= m;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK({ready, done, nack, bus.scl, bus.sda}, 5'h13)
        @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask

    // One whole write; returns at the cycle of the done pulse
    task automatic send(input logic [6:0] a, input byte_t r, input byte_t d);
        int n;
        @(posedge clk_sys);
        tgt_addr <= a;
        reg_addr <= r;
        wr_data <= d;
        req <= 1'b1;
        @(negedge clk_sys);
        while (ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 4000);
        `CHK(done, 1'b1)
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        req = 1'b0;
        strap_m = 2'h0;
        tgt_addr = 7'h00;
        reg_addr = 8'h00;
        wr_data = 8'h00;
        stb_n = 0;
        bad_count = 0;
        checks_done = 0;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            exp_a = {5'h19, strap_bits(m[1:0])};
            stb0 = stb_n;
            seen_addr = 1'b0;
            send(exp_a, 8'hA5 ^ {6'h00, m[1:0]}, 8'h5A ^ {m[1:0], 6'h00});
            `CHK(nack, 1'b0)
            `CHK(seen_addr, 1'b1)
            `CHK(stb_n - stb0, 1)
            `CHK(got_reg, 8'hA5 ^ {6'h00, m[1:0]})
            `CHK(got_data, 8'h5A ^ {m[1:0], 6'h00})
            `CHK(addressed, 1'b0)
            // One strap bit and the prefix low bit wrong, then wrong prefix, sent back to back
            seen_addr = 1'b0;
            send(exp_a ^ 7'h06, 8'h11, 8'h22);
            `CHK(nack, 1'b1)
            send({5'h18, strap_bits(m[1:0])}, 8'h33, 8'h44);
            `CHK(nack, 1'b1)
            `CHK(seen_addr, 1'b0)
            `CHK(stb_n - stb0, 1)
            // Recovery after a refused transfer, boundary values
            send(exp_a, 8'hFF, 8'h00);
            `CHK({nack, got_reg, got_data}, 17'h0FF00)
            `CHK(stb_n - stb0, 2)
        end
        final_report();
    end

    // Sixteen transfers of at most about 1430 cycles each, with margin
    initial begin
        repeat (60000) @(posedge clk_sys);
        bad_count++;
        final_report();
    end
endmodule
